// ---- core/hpdpc_defs.vh ----
// Purpose: Constants for the headphone driver power and protection controller.
// Assumes: 8-bit paged control registers, one 50 MHz clock.
// Notes:   Offsets are register indices within a page; field positions are bit numbers.
`ifndef HPDPC_DEFS_VH
`define HPDPC_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define HPDPC_PAGE_SEL        7'h00
`define HPDPC_HEADSET_STATUS  7'h0d
`define HPDPC_OUTPUT_CONFIG   7'h0e
`define HPDPC_DAC_POWER       7'h25
`define HPDPC_SHORT_CONFIG    7'h26
`define HPDPC_SOFT_RAMP       7'h28
`define HPDPC_DELAY_IDLE      7'h2a
`define HPDPC_SHORT_STATUS    7'h5f
`define HPDPC_JACK_CTRL_A     7'h60
`define HPDPC_JACK_CTRL_B     7'h61
`define HPDPC_FILTER_PATH     7'h6b
`define HPDPC_COEF_FIRST      7'h01
`define HPDPC_COEF_LAST       7'h34
`define HPDPC_COEF_DEPTH      52

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HPDPC_CFG_TYPE_HI     7
`define HPDPC_CFG_TYPE_LO     6
`define HPDPC_CFG_MIX_BIT     3
`define HPDPC_CFG_ELSE_BIT    2
`define HPDPC_DAC_LEFT_BIT    7
`define HPDPC_DAC_RIGHT_BIT   6
`define HPDPC_SC_EN_BIT       2
`define HPDPC_SC_AUTO_BIT     1
`define HPDPC_RAMP_EN_BIT     0
`define HPDPC_JACK_EN_BIT     7
`define HPDPC_FILTER_EN_BIT   3

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define HPDPC_RAMP_RESET      8'h01
`define HPDPC_ZERO_BYTE       8'h00
`define HPDPC_ATT_MAX         4'hf
`define HPDPC_IDLE_ACTIVE     2'h3
`define HPDPC_CFG_AC_COUPLED  2'h3

// ----------------------------------------------------------------------------
// Timing: a millisecond tick drives the power-up delay and the gain ramp
// ----------------------------------------------------------------------------
`define HPDPC_CLK_PERIOD_NS   20
`define HPDPC_TICK_NS         1000000
`define HPDPC_DLY_MS_0        12'd0
`define HPDPC_DLY_MS_1        12'd1
`define HPDPC_DLY_MS_2        12'd2
`define HPDPC_DLY_MS_3        12'd5
`define HPDPC_DLY_MS_4        12'd10
`define HPDPC_DLY_MS_5        12'd20
`define HPDPC_DLY_MS_6        12'd50
`define HPDPC_DLY_MS_7        12'd100
`define HPDPC_DLY_MS_8        12'd200
`define HPDPC_DLY_MS_9        12'd500
`define HPDPC_DLY_MS_10       12'd1000
`define HPDPC_DLY_MS_11       12'd1500
`define HPDPC_DLY_MS_12       12'd2000
`define HPDPC_DLY_MS_13       12'd2500
`define HPDPC_DLY_MS_14       12'd3000
`define HPDPC_DLY_MS_15       12'd4000

`endif

// ---- core/hpdpc_coef_mem.v ----
// Purpose: Filter coefficient store shared by playback and record-only processing.
// Assumes: One host write port, host read port and filter read port, all registered.
// Notes:   Read data appear one clock after the address.
`default_nettype none
`include "hpdpc_defs.vh"

module hpdpc_coef_mem #(
  parameter DEPTH = `HPDPC_COEF_DEPTH,
  parameter AW    = 6
) (
  input  wire          mclk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] host_addr,
  output reg  [7:0]    host_data,
  input  wire [AW-1:0] dsp_addr,
  output reg  [7:0]    dsp_data
);

  reg [7:0] mem [0:DEPTH-1];

  // Writes and both registered reads; no reset so it maps to a RAM.
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    host_data <= mem[host_addr];
    dsp_data  <= mem[dsp_addr];
  end

endmodule // hpdpc_coef_mem

`default_nettype wire

// ---- core/hpdpc_top.v ----
// Purpose: Power-up sequencing, idle level, soft gain ramp and short protection for
//          four headphone drivers, jack detection status and the record filter path.
// Assumes: Analog status inputs arrive asynchronously; registers on a simple paged port.
// Notes:   Read data return two clocks after the read strobe.
//
// What this block does
// - Drivers power up muted and unmute after a selectable delay, from zero up to four seconds.
// - Powered-down pins idle high impedance, weakly at common mode, or half supply.
// - With ramp enabled, gain starts heavily attenuated and steps to programmed value.
// - Shorted drivers limit current; status register shows protection state per driver.
// - Automatic shutdown powers a shorted driver down without host action.
// - Shut driver stays off, flag held, until host commands down then up.
// - Plug insertion and headset type are detected and readable in status.
// - AC-coupled outputs may report mono and stereo headphones inaccurately.
// - Record-only mode closes four switches routing ADC data through filters.
// - Record filters share coefficient registers 1 to 52 of page one.
// - Filter path is active only while enabled and both DACs are off.
// - Direct DAC route valid only with no other DAC route and no mixing.
`default_nettype none
`include "hpdpc_defs.vh"

module hpdpc_top #(
  parameter NDRV        = 4,
  parameter TICK_CYCLES = `HPDPC_TICK_NS / `HPDPC_CLK_PERIOD_NS
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [6:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  output reg               reg_rvalid,
  input  wire [NDRV-1:0]   short_detect,
  input  wire              jack_inserted,
  input  wire [1:0]        headset_type,
  input  wire [5:0]        coef_addr,
  output wire [7:0]        coef_rdata,
  output wire [NDRV-1:0]   driver_power_on,
  output wire [NDRV-1:0]   driver_mute,
  output wire [NDRV-1:0]   current_limit,
  output wire [4*NDRV-1:0] driver_atten,
  output wire [2*NDRV-1:0] driver_idle_mode,
  output reg  [1:0]        powerup_scheme,
  output reg  [1:0]        dac_power,
  output reg  [1:0]        direct_dac_driver_route,
  output reg               record_filter_switch_first,
  output reg               record_filter_switch_second,
  output reg               record_filter_switch_third,
  output reg               record_filter_switch_last
);

  // Bit 0 of a state code powers the driver and bit 1 mutes it, so both outputs are flops.
  localparam ST_OFF   = 3'd0;
  localparam ST_DELAY = 3'd3;
  localparam ST_RAMP  = 3'd1;
  localparam ST_ON    = 3'd5;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg [7:0] page_q;
  reg [3:0] hs_ctrl_q;
  reg [7:0] cfg_q;
  reg [7:0] dacp_q;
  reg [7:0] sc_cfg_q;
  reg [7:0] ramp_q;
  reg [7:0] dly_q;
  reg [7:0] jack_a_q;
  reg [7:0] jack_b_q;
  reg [7:0] filt_q;
  reg [7:0] rd_pre_q;
  reg       rd_mem_q;
  reg       rd_pend_q;

  wire             page0 = (page_q == `HPDPC_ZERO_BYTE);
  wire             coef_hit = !page0 && (reg_addr >= `HPDPC_COEF_FIRST)
                              && (reg_addr <= `HPDPC_COEF_LAST);
  wire [6:0]       coef_off = reg_addr - `HPDPC_COEF_FIRST;
  wire [7:0]       coef_host_data;
  wire [NDRV-1:0]  drv_req = sc_cfg_q[7:8-NDRV];
  wire             sc_en = sc_cfg_q[`HPDPC_SC_EN_BIT];
  wire             sc_auto = sc_cfg_q[`HPDPC_SC_AUTO_BIT];
  wire             ramp_en = ramp_q[`HPDPC_RAMP_EN_BIT];
  wire [3:0]       ramp_target = ramp_q[7:4];
  wire [1:0]       cfg_type = cfg_q[`HPDPC_CFG_TYPE_HI:`HPDPC_CFG_TYPE_LO];

  // --------------------------------------------------------------------------
  // Synchronisers for analog status inputs
  // --------------------------------------------------------------------------
  reg [NDRV-1:0] sc_m_q;
  reg [NDRV-1:0] sc_s_q;
  reg [2:0]      jk_m_q;
  reg [2:0]      jk_s_q;

  // Two flops per asynchronous input before any logic reads it.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sc_m_q <= {NDRV{1'b0}};
      sc_s_q <= {NDRV{1'b0}};
      jk_m_q <= 3'h0;
      jk_s_q <= 3'h0;
    end else begin
      sc_m_q <= short_detect;
      sc_s_q <= sc_m_q;
      jk_m_q <= {headset_type, jack_inserted};
      jk_s_q <= jk_m_q;
    end
  end

  // --------------------------------------------------------------------------
  // Detection status capture
  // --------------------------------------------------------------------------
  reg       ins_q;
  reg [1:0] type_q;

  // Result is captured only while detection is enabled; cleared when unplugged.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ins_q  <= 1'b0;
      type_q <= 2'h0;
    end else if (jack_a_q[`HPDPC_JACK_EN_BIT]) begin
      ins_q  <= jk_s_q[0];
      // The mono/stereo bit passes unqualified even when AC-coupled.
      type_q <= jk_s_q[0] ? jk_s_q[2:1] : 2'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes and reads
  // --------------------------------------------------------------------------
  // Page 0 control writes; page 1 coefficient writes go to the store.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_q    <= `HPDPC_ZERO_BYTE;
      hs_ctrl_q <= 4'h0;
      cfg_q     <= `HPDPC_ZERO_BYTE;
      dacp_q    <= `HPDPC_ZERO_BYTE;
      sc_cfg_q  <= `HPDPC_ZERO_BYTE;
      ramp_q    <= `HPDPC_RAMP_RESET;
      dly_q     <= `HPDPC_ZERO_BYTE;
      jack_a_q  <= `HPDPC_ZERO_BYTE;
      jack_b_q  <= `HPDPC_ZERO_BYTE;
      filt_q    <= `HPDPC_ZERO_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `HPDPC_PAGE_SEL) begin
        page_q <= reg_wdata;
      end else if (page0) begin
        case (reg_addr)
          `HPDPC_HEADSET_STATUS: hs_ctrl_q <= reg_wdata[3:0];
          `HPDPC_OUTPUT_CONFIG:  cfg_q     <= reg_wdata;
          `HPDPC_DAC_POWER:      dacp_q    <= reg_wdata;
          `HPDPC_SHORT_CONFIG:   sc_cfg_q  <= reg_wdata;
          `HPDPC_SOFT_RAMP:      ramp_q    <= reg_wdata;
          `HPDPC_DELAY_IDLE:     dly_q     <= reg_wdata;
          `HPDPC_JACK_CTRL_A:    jack_a_q  <= reg_wdata;
          `HPDPC_JACK_CTRL_B:    jack_b_q  <= reg_wdata;
          `HPDPC_FILTER_PATH:    filt_q    <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  wire [NDRV-1:0] lim_v;
  wire [NDRV-1:0] flag_v;

  // First read stage selects a register; the coefficient store reads in parallel.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_pre_q  <= `HPDPC_ZERO_BYTE;
      rd_mem_q  <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= reg_rd;
      rd_mem_q  <= coef_hit;
      if (reg_addr == `HPDPC_PAGE_SEL) begin
        rd_pre_q <= page_q;
      end else if (!page0) begin
        rd_pre_q <= `HPDPC_ZERO_BYTE;
      end else begin
        case (reg_addr)
          `HPDPC_HEADSET_STATUS: rd_pre_q <= {1'b0, type_q, ins_q, hs_ctrl_q};
          `HPDPC_OUTPUT_CONFIG:  rd_pre_q <= cfg_q;
          `HPDPC_DAC_POWER:      rd_pre_q <= dacp_q;
          `HPDPC_SHORT_CONFIG:   rd_pre_q <= sc_cfg_q;
          `HPDPC_SOFT_RAMP:      rd_pre_q <= ramp_q;
          `HPDPC_DELAY_IDLE:     rd_pre_q <= dly_q;
          `HPDPC_SHORT_STATUS:   rd_pre_q <= {lim_v, flag_v};
          `HPDPC_JACK_CTRL_A:    rd_pre_q <= jack_a_q;
          `HPDPC_JACK_CTRL_B:    rd_pre_q <= jack_b_q;
          `HPDPC_FILTER_PATH:    rd_pre_q <= filt_q;
          default:               rd_pre_q <= `HPDPC_ZERO_BYTE;
        endcase
      end
    end
  end

  // Second read stage presents the data with a one-cycle valid.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= `HPDPC_ZERO_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_q;
      if (rd_pend_q) begin
        reg_rdata <= rd_mem_q ? coef_host_data : rd_pre_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Coefficient store shared with playback processing
  // --------------------------------------------------------------------------
  hpdpc_coef_mem #(
    .DEPTH (`HPDPC_COEF_DEPTH),
    .AW    (6)
  ) u_coef (
    .mclk      (mclk),
    .wr_en     (reg_wr && coef_hit),
    .wr_addr   (coef_off[5:0]),
    .wr_data   (reg_wdata),
    .host_addr (coef_off[5:0]),
    .host_data (coef_host_data),
    .dsp_addr  (coef_addr),
    .dsp_data  (coef_rdata)
  );

  // --------------------------------------------------------------------------
  // Path control: DAC power, record filter switches, direct route, scheme
  // --------------------------------------------------------------------------
  wire dac_l = dacp_q[`HPDPC_DAC_LEFT_BIT];
  wire dac_r = dacp_q[`HPDPC_DAC_RIGHT_BIT];
  wire filt_on = filt_q[`HPDPC_FILTER_EN_BIT] && !dac_l && !dac_r;
  wire direct_ok = !cfg_q[`HPDPC_CFG_ELSE_BIT] && !cfg_q[`HPDPC_CFG_MIX_BIT];

  // All four record switches close together; a DAC powering up reopens them.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      dac_power                   <= 2'h0;
      record_filter_switch_first  <= 1'b0;
      record_filter_switch_second <= 1'b0;
      record_filter_switch_third  <= 1'b0;
      record_filter_switch_last   <= 1'b0;
      direct_dac_driver_route     <= 2'h0;
      powerup_scheme              <= 2'h0;
    end else begin
      dac_power                   <= {dac_l, dac_r};
      record_filter_switch_first  <= filt_on;
      record_filter_switch_second <= filt_on;
      record_filter_switch_third  <= filt_on;
      record_filter_switch_last   <= filt_on;
      direct_dac_driver_route     <= direct_ok ? cfg_q[1:0] : 2'h0;
      powerup_scheme              <= cfg_type;
    end
  end

  // --------------------------------------------------------------------------
  // Millisecond tick and delay selection
  // --------------------------------------------------------------------------
  reg  [15:0] tick_cnt_q;
  reg         tick_q;
  reg  [11:0] dly_ms;

  // Free-running prescaler; one pulse per millisecond.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[15:0] - 16'h0001) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // Delay select to milliseconds, from instantaneous up to four seconds.
  always @* begin
    case (dly_q[7:4])
      4'h0:    dly_ms = `HPDPC_DLY_MS_0;
      4'h1:    dly_ms = `HPDPC_DLY_MS_1;
      4'h2:    dly_ms = `HPDPC_DLY_MS_2;
      4'h3:    dly_ms = `HPDPC_DLY_MS_3;
      4'h4:    dly_ms = `HPDPC_DLY_MS_4;
      4'h5:    dly_ms = `HPDPC_DLY_MS_5;
      4'h6:    dly_ms = `HPDPC_DLY_MS_6;
      4'h7:    dly_ms = `HPDPC_DLY_MS_7;
      4'h8:    dly_ms = `HPDPC_DLY_MS_8;
      4'h9:    dly_ms = `HPDPC_DLY_MS_9;
      4'ha:    dly_ms = `HPDPC_DLY_MS_10;
      4'hb:    dly_ms = `HPDPC_DLY_MS_11;
      4'hc:    dly_ms = `HPDPC_DLY_MS_12;
      4'hd:    dly_ms = `HPDPC_DLY_MS_13;
      4'he:    dly_ms = `HPDPC_DLY_MS_14;
      default: dly_ms = `HPDPC_DLY_MS_15;
    endcase
  end

  // --------------------------------------------------------------------------
  // Per-driver sequencer and protection
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NDRV; i = i + 1) begin : g_drv
      reg  [2:0]  st_q;
      reg  [11:0] cnt_q;
      reg  [3:0]  att_q;
      reg  [1:0]  idle_q;
      reg         req_q;
      reg         shut_q;
      reg         flag_q;
      reg         down_q;
      reg         lim_q;
      wire        req = drv_req[i];
      wire        rise = req && !req_q;
      wire        live = st_q[0];
      wire        short_hit = sc_en && sc_s_q[i] && live;
      wire        rearm = rise && down_q;

      // Protection: flag set on a short, shutdown too when automatic; a set beats a clear.
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          req_q  <= 1'b0;
          shut_q <= 1'b0;
          flag_q <= 1'b0;
          down_q <= 1'b0;
          lim_q  <= 1'b0;
        end else begin
          req_q <= req;
          lim_q <= short_hit && !shut_q;
          if (short_hit && sc_auto) begin
            shut_q <= 1'b1;
          end else if (rearm) begin
            shut_q <= 1'b0;
          end
          if (short_hit) begin
            flag_q <= 1'b1;
          end else if (rearm) begin
            flag_q <= 1'b0;
          end
          if ((flag_q || shut_q) && !req) begin
            down_q <= 1'b1;
          end else if (rise) begin
            down_q <= 1'b0;
          end
        end
      end

      // Power sequence: delay with mute, then soft ramp, then programmed gain.
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          st_q   <= ST_OFF;
          cnt_q  <= 12'h000;
          att_q  <= `HPDPC_ATT_MAX;
          idle_q <= 2'h0;
        end else if (shut_q || !req) begin
          st_q   <= ST_OFF;
          att_q  <= `HPDPC_ATT_MAX;
          idle_q <= dly_q[3:2];
        end else begin
          idle_q <= `HPDPC_IDLE_ACTIVE;
          case (st_q)
            ST_OFF: begin
              st_q  <= ST_DELAY;
              cnt_q <= dly_ms;
            end
            ST_DELAY: begin
              if (cnt_q == 12'h000) begin
                st_q  <= ST_RAMP;
                att_q <= ramp_en ? `HPDPC_ATT_MAX : ramp_target;
              end else if (tick_q) begin
                cnt_q <= cnt_q - 12'h001;
              end
            end
            ST_RAMP: begin
              if (att_q <= ramp_target) begin
                st_q  <= ST_ON;
                att_q <= ramp_target;
              end else if (tick_q) begin
                att_q <= att_q - 4'h1;
              end
            end
            ST_ON: begin
              att_q <= ramp_target;
            end
            default: begin
              st_q <= ST_OFF;
            end
          endcase
        end
      end

      assign driver_power_on[i]         = live;
      assign driver_mute[i]             = st_q[1];
      assign current_limit[i]           = lim_q;
      assign lim_v[i]                   = lim_q;
      assign flag_v[i]                  = flag_q;
      assign driver_atten[4*i+3:4*i]    = att_q;
      assign driver_idle_mode[2*i+1:2*i] = idle_q;
    end
  endgenerate

endmodule // hpdpc_top

`default_nettype wire

// ---- dv/hpdpc_assertions.sv ----
// Purpose: Port checks for the headphone driver controller.
// Assumes: One clock; driver 0 stands for all four.
// Notes:   Shadow logic copies page, short and ramp settings.
`default_nettype none
module hpdpc_assertions #(
  parameter NDRV = 4
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [6:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_rvalid,
  input wire logic [NDRV-1:0]   driver_power_on,
  input wire logic [NDRV-1:0]   driver_mute,
  input wire logic [NDRV-1:0]   current_limit,
  input wire logic [4*NDRV-1:0] driver_atten,
  input wire logic [2*NDRV-1:0] driver_idle_mode,
  input wire logic [1:0]        dac_power,
  input wire logic              record_filter_switch_first,
  input wire logic              record_filter_switch_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       page_q;
  logic [1:0] sc_q;
  logic       ramp_q;
  // ------------------------------------------------------------
  // Shadow settings
  // ------------------------------------------------------------
  // Copies of the settings the checks depend on, taken from host writes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_q <= 1'b0;
      sc_q   <= 2'h0;
      ramp_q <= 1'b1;
    end else if (reg_wr) begin
      page_q <= (reg_addr == 7'h00) ? reg_wdata[0] : page_q;
      sc_q   <= (!page_q && reg_addr == 7'h26) ? reg_wdata[2:1] : sc_q;
      ramp_q <= (!page_q && reg_addr == 7'h28) ? reg_wdata[0] : ramp_q;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_ans; reg_rd |-> ##2 reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_cause; reg_rvalid |-> $past(reg_rd, 2); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
  property p_mute_pw; driver_mute[0] |-> driver_power_on[0]; endproperty
  a_mute_pw: assert property (p_mute_pw) else $error("mute while off");
  property p_start_mute; $rose(driver_power_on[0]) |-> driver_mute[0]; endproperty
  a_start_mute: assert property (p_start_mute) else $error("power-up not muted");
  property p_idle; driver_power_on[0] |-> driver_idle_mode[1:0] == 2'h3; endproperty
  a_idle: assert property (p_idle) else $error("idle level while on");
  property p_step; ramp_q && driver_power_on[0] && $past(driver_power_on[0])
    && !$past(driver_mute[0]) && $changed(driver_atten[3:0])
    |-> driver_atten[3:0] == $past(driver_atten[3:0]) - 4'h1; endproperty
  a_step: assert property (p_step) else $error("gain step not one");
  property p_auto; current_limit[0] && sc_q == 2'h3 |-> ##[1:4] !driver_power_on[0]; endproperty
  a_auto: assert property (p_auto) else $error("shorted driver stays on");
  property p_filt; $rose(|dac_power) |-> ##[0:1] !record_filter_switch_first; endproperty
  a_filt: assert property (p_filt) else $error("filter path with DAC on");
  property p_sw; record_filter_switch_first == record_filter_switch_last; endproperty
  a_sw: assert property (p_sw) else $error("switches disagree");
endmodule // hpdpc_assertions
`default_nettype wire

// ---- dv/hpdpc_jack_model.sv ----
// Purpose: Jack and headphone load seen by the four drivers.
// Assumes: Fully differential wiring with a spring terminal.
// Notes:   Type lines float and toggle while the jack is empty.
`default_nettype none
module hpdpc_jack_model #(
  parameter NDRV = 4
) (
  input  wire logic            mclk,
  input  wire logic [NDRV-1:0] driver_power_on,
  input  wire logic            plug,
  input  wire logic [1:0]      kind,
  output logic      [NDRV-1:0] short_detect,
  output logic                 jack_inserted,
  output logic      [1:0]      headset_type
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_q = 1'b0;
  // Floating sense lines change every clock.
  always @(posedge mclk) float_q <= ~float_q;
  // Pulling the plug grounds the left pair: a short on any powered left driver.
  assign short_detect  = driver_power_on & {{(NDRV-2){1'b0}}, {2{~plug}}};
  assign jack_inserted = plug;
  assign headset_type  = plug ? kind : {float_q, ~float_q};
endmodule // hpdpc_jack_model
`default_nettype wire

// ---- dv/hpdpc_top_test.sv ----
// Purpose: Self-checking bench for the headphone driver controller.
// Assumes: Read answers come two clocks after the strobe.
// Notes:   Tick shortened to ten clocks; delays scale with it.
`default_nettype none
module hpdpc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  logic        mclk, rst, reg_wr, reg_rd, reg_rvalid, jack_inserted, plug, s1, s2, s3, s4;
  logic [1:0]  headset_type, kind, powerup_scheme, dac_power, route;
  logic [3:0]  short_detect, driver_power_on, driver_mute, current_limit;
  logic [5:0]  coef_addr;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, coef_rdata, driver_idle_mode;
  logic [15:0] driver_atten;
  logic [7:0]  exp_q[$];
  int          n_errors = 0;
  int          n_checks = 0;
  hpdpc_top #(.NDRV(4), .TICK_CYCLES(TICK)) i_dut (.*, .direct_dac_driver_route(route),
    .record_filter_switch_first(s1), .record_filter_switch_second(s2),
    .record_filter_switch_third(s3), .record_filter_switch_last(s4));
  hpdpc_jack_model #(.NDRV(4)) i_jack (.*);
  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    cyc(1);
    reg_rd = 1'b0;
    cyc(3);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Each read answer is compared with the oldest expectation.
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) chk(reg_rdata, exp_q.pop_front());
  end
  // Main sequence: registers, power-up, short protection, then data paths.
  initial begin
    int n;
    logic [7:0] d1, d2;
    logic [1:0] ty;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, coef_addr} = {1'b1, 23'h0};
    plug = 1'b1;
    kind = 2'h2;
    void'($urandom(32'h33f8));
    cyc(5);
    rst = 1'b0;
    rd(7'h28, 8'h01);
    wr(7'h5f, 8'hff);
    rd(7'h5f, 8'h00);
    wr(7'h10, 8'hff);
    rd(7'h10, 8'h00);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    wr(7'h00, 8'h01);
    wr(7'h01, d1);
    wr(7'h34, d2);
    rd(7'h01, d1);
    rd(7'h35, 8'h00);
    coef_addr = 6'd51;
    cyc(2);
    chk(coef_rdata, d2);
    wr(7'h00, 8'h00);
    $display("Register test done");
    ty = 2'($urandom);
    wr(7'h0e, {ty, 6'h00});
    for (int k = 0; k < 3; k++) begin
      wr(7'h2a, {4'h3, 2'(k), 2'h0});
      cyc(2);
      chk({6'h0, driver_idle_mode[3:2]}, 8'(k));
    end
    chk({6'h0, powerup_scheme}, {6'h0, ty});
    wr(7'h28, 8'h31);
    wr(7'h26, 8'h10);
    cyc(2);
    chk({driver_mute, driver_power_on}, 8'h11);
    for (n = 0; n < 300 && driver_mute[0] !== 1'b0; n++) cyc(1);
    chk({7'h0, n >= 40 && n <= 54}, 8'h01);
    chk({4'h0, driver_atten[3:0]}, 8'h0f);
    for (n = 0; n < 300 && driver_atten[3:0] !== 4'h3; n++) cyc(1);
    chk({7'h0, n >= 100 && n <= 130}, 8'h01);
    $display("Power-up test done");
    wr(7'h26, 8'h14);
    plug = 1'b0;
    cyc(6);
    chk({driver_power_on, current_limit}, 8'h11);
    rd(7'h5f, 8'h11);
    wr(7'h26, 8'h16);
    cyc(5);
    chk({4'h0, driver_power_on}, 8'h00);
    plug = 1'b1;
    wr(7'h26, 8'h16);
    cyc(3);
    chk({4'h0, driver_power_on}, 8'h00);
    rd(7'h5f, 8'h01);
    wr(7'h26, 8'h06);
    wr(7'h26, 8'h16);
    cyc(3);
    chk({4'h0, driver_power_on}, 8'h01);
    rd(7'h5f, 8'h00);
    $display("Short test done");
    wr(7'h2a, 8'h04);
    wr(7'h28, 8'h50);
    wr(7'h26, 8'h20);
    cyc(2);
    for (n = 0; n < 300 && driver_mute[1] !== 1'b0; n++) cyc(1);
    chk({6'h0, driver_power_on[1], n <= 3}, 8'h03);
    chk({4'h0, driver_atten[7:4]}, 8'h05);
    wr(7'h60, 8'h80);
    wr(7'h0d, 8'h0a);
    cyc(4);
    rd(7'h0d, 8'h5a);
    plug = 1'b0;
    cyc(4);
    rd(7'h0d, 8'h0a);
    plug = 1'b1;
    wr(7'h25, 8'hc0);
    wr(7'h6b, 8'h08);
    cyc(3);
    chk({dac_power, 2'h0, s1, s2, s3, s4}, 8'hc0);
    wr(7'h25, 8'h00);
    cyc(3);
    chk({dac_power, 2'h0, s1, s2, s3, s4}, 8'h0f);
    wr(7'h25, 8'h40);
    cyc(3);
    chk({dac_power, 2'h0, s1, s2, s3, s4}, 8'h40);
    wr(7'h0e, {ty, 6'h03});
    cyc(3);
    chk({6'h0, route}, 8'h03);
    wr(7'h0e, {ty, 6'h0b});
    cyc(3);
    chk({6'h0, route}, 8'h00);
    $display("Path test done");
    summarize();
  end
  // Cuts a hung run short far beyond the expected length.
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("Watchdog expired at %0t", $time);
    summarize();
  end
endmodule // hpdpc_top_test
bind hpdpc_top hpdpc_assertions #(.NDRV(NDRV)) i_chk (.*);
`default_nettype wire
